// *** design/rwg_pkg.sv ***
// constants, types and register map of the ringing waveform generator
package rwg_pkg;
  localparam int CLK_NS      = 40;
  localparam int CLK_HZ      = 25_000_000;
  localparam int SINE_HZ     = 1000;
  localparam int SINE_DIV    = CLK_HZ / SINE_HZ;
  localparam int STEP_NS     = 125_000;
  localparam int STEP_DIV    = STEP_NS / CLK_NS;
  localparam int STEP_W      = $clog2(STEP_DIV);
  // direct register indices; byte address is four times the index
  localparam logic [7:0] IDX_IND_DATA  = 8'h1c;
  localparam logic [7:0] IDX_IND_ADDR  = 8'h1e;
  localparam logic [7:0] IDX_IND_STAT  = 8'h1f;
  localparam logic [7:0] IDX_RING_CTRL = 8'h22;
  localparam logic [7:0] IDX_ACT       = 8'h30;
  localparam logic [7:0] IDX_INACT     = 8'h32;
  localparam logic [7:0] IDX_LINE      = 8'h40;
  localparam logic [7:0] IDX_BAT       = 8'h4a;
  // indirect register addresses
  localparam logic [7:0] IND_OFS   = 8'h13;
  localparam logic [7:0] IND_FREQ  = 8'h14;
  localparam logic [7:0] IND_AMP   = 8'h15;
  localparam logic [7:0] IND_PHASE = 8'h16;
  localparam logic [7:0] IND_HEAD  = 8'h28;
  localparam int IND_WR_BIT = 8;
  // ringing control fields
  localparam int CTRL_SHAPE = 0;
  localparam int CTRL_OFS   = 1;
  localparam int CTRL_OSC   = 2;
  localparam int CTRL_TIE   = 3;
  localparam int CTRL_TAE   = 4;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [2:0]  LINE_OPEN = 3'h0;
  localparam logic [2:0]  LINE_OHT  = 3'h2;
  localparam logic [2:0]  LINE_RING = 3'h4;
  typedef enum logic [1:0] {
    RWG_IDLE     = 2'b00,
    RWG_ACTIVE   = 2'b01,
    RWG_INACTIVE = 2'b10
  } rwg_state_t;
  typedef struct packed {
    logic [15:0] dc_ofs;
    logic [15:0] freq;
    logic [15:0] amp;
    logic [15:0] phase;
  } rwg_coef_t;
endpackage : rwg_pkg

// *** design/rwg_ind_mem.sv ***
// indirect register store with registered read port
`timescale 1ns/100ps
module rwg_ind_mem #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic          we,
  input  wire logic          re,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata,
  output logic               rvalid
);
  logic [DW-1:0] mem [2**AW];
  always_ff @(posedge clk) begin
    if (we) mem[addr] <= wdata;
    if (re) rdata <= mem[addr];
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rvalid <= 1'b0;
    else         rvalid <= re;
  end
endmodule : rwg_ind_mem

// *** design/rwg_cadence.sv ***
// shared cadence counter in 125 us steps with limit compare
`timescale 1ns/100ps
module rwg_cadence #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         step,
  input  wire logic         clear,
  input  wire logic         enable,
  input  wire logic [W-1:0] limit,
  output logic              expire,
  output logic      [W-1:0] count
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  assign expire     = enable & step & (count_reg >= limit);
  // saturate so a disabled timer never wraps into a false expiry
  assign count_next = (clear | expire) ? '0 :
                      (step && count_reg != '1) ? count_reg + 1'b1 : count_reg; // see R18
  assign count      = count_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) count_reg <= '0;
    else         count_reg <= count_next;
  end
  a_count_clear: assert property (@(posedge clk) disable iff (!resetn)
    expire |=> count_reg == '0) else $error("cadence count not cleared on expiry"); // see R18
endmodule : rwg_cadence

// *** design/rwg_top.sv ***
// ringing waveform generator: apb slave, cadence state machine, oscillator
//
// Notes on behaviour
// R01: sine ring comes from a two-pole resonant oscillator with programmable coefficients.
// R02: the sine oscillator updates once per millisecond, not at 8 kHz.
// R03: active and inactive timers, each up to 8 seconds, like tone timers.
// R04: cadence timers also move the line into and out of ringing.
// R05: writing 100 to linefeed_state enters ringing and starts the first ring.
// R06: active timer expiry stops the waveform; line goes to on-hook transmission.
// R07: inactive timer expiry starts a new active ring period.
// R08: cadence repeats only while both timer enables set and ringing selected.
// R09: ring_wave_shape_select 0 gives sine, 1 gives trapezoid.
// R10: software loads frequency, amplitude and zero phase coefficients correctly.
// R11: trapezoid adds or subtracts ring_freq_coeff each step toward the amplitude.
// R12: ramp step and half period together set the trapezoid crest factor.
// R13: software keeps tone generator two off while ringing.
// R14: coefficients live in indirect space behind direct registers 28 to 31.
// R15: software picks a ring peak above open_circuit_voltage.
// R16: ring_offset_enable adds ring_dc_offset to the ringing waveform.
// R17: cadence timers count 125 microsecond steps, 0 to 8 seconds.
// R18: each expiry clears the shared 16-bit counter, then counts the other limit.
// R19: sine sample is 2*coeff*previous minus the one before, seeded at start.
`timescale 1ns/100ps
module rwg_top
  import rwg_pkg::*;
#(
  parameter int SINE_DIV_P = SINE_DIV,
  parameter int IND_AW     = 6
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [15:0] ring_sample,
  output logic      [2:0]  line_state,
  output logic             ring_on
);
  localparam int SDW = $clog2(SINE_DIV_P);

  if (SINE_DIV_P < 2) begin : g_bad_div
    $error("sine divider must be at least 2");
  end
  if (2**IND_AW <= int'(IND_HEAD)) begin : g_bad_aw
    $error("indirect store too small for the ringing registers");
  end

  function automatic logic [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'sd32767)       sat16 = 16'h7fff;
    else if (v < -18'sd32768) sat16 = 16'h8000;
    else                      sat16 = v[15:0];
  endfunction : sat16

  // apb access: one access cycle per transfer, answered one cycle later
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  wire         acc = psel & penable & ~pready_reg;
  wire         wr  = acc & pwrite;
  wire         rd  = acc & ~pwrite;
  wire  [7:0]  idx = paddr[9:2];
  wire         aligned = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
  wire         hit = aligned && (idx == IDX_IND_DATA || idx == IDX_IND_ADDR || idx == IDX_IND_STAT ||
                     idx == IDX_RING_CTRL || idx == IDX_ACT || idx == IDX_INACT ||
                     idx == IDX_LINE || idx == IDX_BAT);
  wire         w_ctrl  = wr & hit & (idx == IDX_RING_CTRL);
  wire         w_act   = wr & hit & (idx == IDX_ACT);
  wire         w_inact = wr & hit & (idx == IDX_INACT);
  wire         w_line  = wr & hit & (idx == IDX_LINE);
  wire         w_bat   = wr & hit & (idx == IDX_BAT);
  wire         w_idata = wr & hit & (idx == IDX_IND_DATA);
  wire         w_iaddr = wr & hit & (idx == IDX_IND_ADDR);

  // software registers
  logic [7:0]  ctrl_reg;
  logic [15:0] act_reg;
  logic [15:0] inact_reg;
  logic [2:0]  line_reg;
  logic [5:0]  bat_reg;
  logic [15:0] ind_data_reg;
  logic        ind_busy_reg;
  rwg_coef_t   coef_reg;
  rwg_coef_t   coef_next;
  logic [3:0]  head_reg;
  logic [3:0]  head_next;

  // indirect window: address write with the write bit stores, without it fetches
  wire         ind_we = w_iaddr & pwdata[IND_WR_BIT]; // see R14
  wire         ind_re = w_iaddr & ~pwdata[IND_WR_BIT];
  wire  [7:0]  ind_a  = pwdata[7:0];
  logic [15:0] mem_rdata;
  logic        mem_rvalid;

  rwg_ind_mem #(.AW(IND_AW), .DW(16)) u_mem (
    .clk    (clk),
    .resetn (resetn),
    .we     (ind_we),
    .re     (ind_re),
    .addr   (ind_a[IND_AW-1:0]),
    .wdata  (ind_data_reg),
    .rdata  (mem_rdata),
    .rvalid (mem_rvalid)
  );

  // the oscillator needs all coefficients at once, so writes also land in flops
  assign coef_next.dc_ofs = (ind_we && ind_a == IND_OFS)   ? ind_data_reg : coef_reg.dc_ofs;
  assign coef_next.freq   = (ind_we && ind_a == IND_FREQ)  ? ind_data_reg : coef_reg.freq;
  assign coef_next.amp    = (ind_we && ind_a == IND_AMP)   ? ind_data_reg : coef_reg.amp;
  assign coef_next.phase  = (ind_we && ind_a == IND_PHASE) ? ind_data_reg : coef_reg.phase;
  assign head_next        = (ind_we && ind_a == IND_HEAD)  ? ind_data_reg[3:0] : head_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg     <= CTRL_RST;
      act_reg      <= WORD_RST;
      inact_reg    <= WORD_RST;
      line_reg     <= LINE_OPEN;
      bat_reg      <= '0;
      ind_data_reg <= WORD_RST;
      ind_busy_reg <= 1'b0;
      coef_reg     <= '0;
      head_reg     <= '0;
    end else begin
      if (w_ctrl) ctrl_reg <= pwdata[7:0] & ~(8'h01 << CTRL_OSC);
      if (w_act)   act_reg   <= pwdata[15:0];
      if (w_inact) inact_reg <= pwdata[15:0];
      if (w_line)  line_reg  <= pwdata[2:0];
      if (w_bat)   bat_reg   <= pwdata[5:0];
      // a software write of the data word wins over a late fetch result
      if (w_idata)         ind_data_reg <= pwdata[15:0];
      else if (mem_rvalid) ind_data_reg <= mem_rdata;
      ind_busy_reg <= ind_re | (ind_busy_reg & ~mem_rvalid);
      coef_reg     <= coef_next;
      head_reg     <= head_next;
    end
  end

  wire shape_trap = ctrl_reg[CTRL_SHAPE];
  wire ofs_en     = ctrl_reg[CTRL_OFS];
  wire tae        = ctrl_reg[CTRL_TAE];
  wire tie        = ctrl_reg[CTRL_TIE];

  // cadence state machine
  rwg_state_t  state_reg;
  rwg_state_t  state_next;
  logic        cad_exp;
  logic        step_tick;
  logic        sine_tick;
  wire         ring_sel  = (line_reg == LINE_RING);
  wire         ring_req  = w_line && (pwdata[2:0] == LINE_RING); // see R05
  wire         cad_en    = (state_reg == RWG_ACTIVE) ? tae : (state_reg == RWG_INACTIVE) ? tie : 1'b0;
  wire  [15:0] cad_lim   = (state_reg == RWG_ACTIVE) ? act_reg : inact_reg; // see R03

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RWG_IDLE:     if (ring_req) state_next = RWG_ACTIVE; // see R05
      RWG_ACTIVE: begin
        if (!ring_sel)    state_next = RWG_IDLE; // see R08
        else if (cad_exp) state_next = RWG_INACTIVE; // see R06
      end
      RWG_INACTIVE: begin
        if (!ring_sel)    state_next = RWG_IDLE; // see R08
        else if (cad_exp) state_next = RWG_ACTIVE; // see R07
      end
      default:            state_next = RWG_IDLE;
    endcase
  end

  wire start    = (state_reg != RWG_ACTIVE) && (state_next == RWG_ACTIVE);
  wire cad_clr  = (state_reg == RWG_IDLE) || (state_reg != state_next); // see R18

  rwg_cadence #(.W(16)) u_cad (
    .clk    (clk),
    .resetn (resetn),
    .step   (step_tick),
    .clear  (cad_clr),
    .enable (cad_en),
    .limit  (cad_lim),
    .expire (cad_exp),
    .count  ()
  );

  // prescalers restart with each ring so cadence lengths are exact
  logic [STEP_W-1:0] step_cnt_reg;
  logic [SDW-1:0]    sine_cnt_reg;
  assign step_tick = (step_cnt_reg == STEP_W'(STEP_DIV - 1)); // see R17
  assign sine_tick = (sine_cnt_reg == SDW'(SINE_DIV_P - 1)); // see R02
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= RWG_IDLE;
      step_cnt_reg <= '0;
      sine_cnt_reg <= '0;
    end else begin
      state_reg    <= state_next;
      step_cnt_reg <= (start || step_tick) ? '0 : step_cnt_reg + 1'b1;
      sine_cnt_reg <= (start || sine_tick) ? '0 : sine_cnt_reg + 1'b1;
    end
  end

  // sine: two-pole resonator, y[n] = 2*c*y[n-1] - y[n-2]
  logic signed [15:0] y1_reg;
  logic signed [15:0] y2_reg;
  logic signed [31:0] prod;
  logic signed [17:0] sine_sum;
  assign prod     = $signed(coef_reg.freq) * y1_reg; // see R01
  assign sine_sum = prod[31:14] - 18'(y2_reg); // see R19
  wire   run      = (state_reg == RWG_ACTIVE);

  // trapezoid: linear ramp clipped at the amplitude, direction flips each half period
  logic signed [15:0] trap_reg;
  logic               up_reg;
  logic [15:0]        half_reg;
  wire signed  [17:0] amp18  = 18'($signed({1'b0, coef_reg.amp[14:0]}));
  wire signed  [17:0] freq18 = 18'($signed({1'b0, coef_reg.freq[14:0]}));
  wire signed  [17:0] up18   = 18'(trap_reg) + freq18; // see R11
  wire signed  [17:0] dn18   = 18'(trap_reg) - freq18; // see R11
  wire signed  [17:0] trap18 = up_reg ? ((up18 > amp18) ? amp18 : up18) : ((dn18 < -amp18) ? -amp18 : dn18);
  wire                flip   = (half_reg + 16'h0001 >= coef_reg.phase); // see R12

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      y1_reg   <= '0;
      y2_reg   <= '0;
      trap_reg <= '0;
      up_reg   <= 1'b1;
      half_reg <= '0;
    end else if (start) begin
      y1_reg   <= $signed(coef_reg.amp); // see R19
      y2_reg   <= $signed(coef_reg.phase);
      trap_reg <= '0;
      up_reg   <= 1'b1;
      half_reg <= '0;
    end else if (run) begin
      if (sine_tick && !shape_trap) begin
        y2_reg <= y1_reg;
        y1_reg <= $signed(sat16(sine_sum));
      end
      if (step_tick && shape_trap) begin
        trap_reg <= trap18[15:0];
        up_reg   <= flip ? ~up_reg : up_reg;
        half_reg <= flip ? 16'h0000 : half_reg + 16'h0001;
      end
    end
  end

  wire signed [15:0] wave   = shape_trap ? trap_reg : y1_reg; // see R09
  wire signed [15:0] ofs    = ofs_en ? $signed(coef_reg.dc_ofs) : 16'sh0000; // see R16
  wire signed [17:0] out18  = (run ? 18'(wave) : 18'sd0) + 18'(ofs); // see R04
  wire        [2:0]  ls_nxt = (state_next == RWG_ACTIVE) ? LINE_RING :
                              (state_next == RWG_INACTIVE) ? LINE_OHT : line_reg; // see R06

  // register read selection
  wire [15:0] rd_mux =
    (idx == IDX_IND_DATA)  ? ind_data_reg :
    (idx == IDX_IND_STAT)  ? {15'h0000, ind_busy_reg} :
    (idx == IDX_RING_CTRL) ? {8'h00, ctrl_reg[7:3], ring_on, ctrl_reg[1:0]} :
    (idx == IDX_ACT)       ? act_reg :
    (idx == IDX_INACT)     ? inact_reg :
    (idx == IDX_LINE)      ? {9'h000, line_state, 1'b0, line_reg} :
    (idx == IDX_BAT)       ? {10'h000, bat_reg} : 16'h0000;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
      ring_sample <= '0;
      line_state  <= LINE_OPEN;
      ring_on     <= 1'b0;
    end else begin
      pready_reg  <= acc;
      pslverr_reg <= acc & ~hit;
      prdata_reg  <= (rd && hit) ? {16'h0000, rd_mux} : 32'h0000_0000;
      ring_sample <= sat16(out18);
      line_state  <= ls_nxt;
      ring_on     <= (state_next == RWG_ACTIVE);
    end
  end
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata  = prdata_reg;

  a_ring_start: assert property (@(posedge clk) disable iff (!resetn) // see R05
    (state_reg == RWG_IDLE && ring_req) |=> (state_reg == RWG_ACTIVE) && ring_on && line_state == LINE_RING)
    else $error("ringing did not start on linefeed write");
  a_active_end: assert property (@(posedge clk) disable iff (!resetn) // see R06
    (state_reg == RWG_ACTIVE && ring_sel && cad_exp) |=> !ring_on && line_state == LINE_OHT ##1 !run)
    else $error("active expiry did not move to on-hook transmission");
  a_inactive_end: assert property (@(posedge clk) disable iff (!resetn) // see R07
    (state_reg == RWG_INACTIVE && ring_sel && cad_exp) |=> ring_on && state_reg == RWG_ACTIVE)
    else $error("inactive expiry did not restart ringing");
  a_cad_hold: assert property (@(posedge clk) disable iff (!resetn) // see R08
    (state_reg == RWG_INACTIVE && !tie && ring_sel && !w_line && !w_ctrl) |=> state_reg == RWG_INACTIVE)
    else $error("cadence advanced with inactive timer disabled");
  a_lf_leave: assert property (@(posedge clk) disable iff (!resetn) // see R08
    (state_reg != RWG_IDLE && !ring_sel) |=> state_reg == RWG_IDLE ##1 !ring_on)
    else $error("ringing continued after linefeed left ringing");
  a_sine_rate: assert property (@(posedge clk) disable iff (!resetn) // see R02
    (sine_tick && !start) |=> !sine_tick [*8])
    else $error("sine update ticks too close together");
  a_trap_bound: assert property (@(posedge clk) disable iff (!resetn) // see R11
    (shape_trap && run && !start) |=> (18'(trap_reg) <= amp18 + freq18) && (18'(trap_reg) >= -amp18 - freq18))
    else $error("trapezoid ramp left the amplitude bounds");
  a_idle_offset: assert property (@(posedge clk) disable iff (!resetn) // see R16
    (state_reg == RWG_IDLE && state_next == RWG_IDLE) |=> ring_sample == $past(ofs_en ? coef_reg.dc_ofs : 16'h0000))
    else $error("idle output not equal to selected offset");
  a_ind_shadow: assert property (@(posedge clk) disable iff (!resetn) // see R14
    (ind_we && ind_a == IND_FREQ) |=> coef_reg.freq == $past(ind_data_reg))
    else $error("indirect write did not reach the frequency coefficient");
  a_apb_answer: assert property (@(posedge clk) disable iff (!resetn) // see R14
    acc |=> pready ##1 !pready)
    else $error("apb answer not a single cycle after access");

  a_pslverr_map: assert property (@(posedge clk) disable iff (!resetn) // see R14
    (acc && !hit) |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_sine_seed: assert property (@(posedge clk) disable iff (!resetn) // see R19
    start |=> y1_reg == $past(coef_reg.amp) && y2_reg == $past(coef_reg.phase))
    else $error("oscillator not seeded at ring start");
  a_sine_hold: assert property (@(posedge clk) disable iff (!resetn) // see R02
    (run && !shape_trap && !sine_tick && !start) |=> $stable(y1_reg))
    else $error("sine sample changed between ticks");
  a_step_rate: assert property (@(posedge clk) disable iff (!resetn) // see R17
    (step_tick && !start) |=> !step_tick [*8])
    else $error("cadence step ticks too close together");
  a_trap_hold: assert property (@(posedge clk) disable iff (!resetn) // see R11
    (run && shape_trap && !step_tick && !start) |=> $stable(trap_reg))
    else $error("trapezoid moved between steps");
  a_line_oht: assert property (@(posedge clk) disable iff (!resetn) // see R06
    (state_reg == RWG_INACTIVE) |-> line_state == LINE_OHT && !ring_on)
    else $error("inactive period not shown as on-hook transmission");
  a_inactive_quiet: assert property (@(posedge clk) disable iff (!resetn) // see R04
    (state_reg == RWG_INACTIVE && state_next == RWG_INACTIVE) |=> ring_sample == $past(ofs_en ? coef_reg.dc_ofs : 16'h0000))
    else $error("waveform present during inactive period");
endmodule : rwg_top

// *** testbench/rwg_line_model.sv ***
// behavioural line driver and ringer load, counting ring bursts
`timescale 1ns/100ps
module rwg_line_model
  import rwg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [2:0] line_state,
  input  wire logic       ring_on,
  output int              n_rings
);
  logic ring_on_d;
  // a ringer only reacts to bursts, so each burst start counts once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ring_on_d <= 1'b0;
      n_rings   <= 0;
    end else begin
      ring_on_d <= ring_on;
      if (ring_on && !ring_on_d && line_state == LINE_RING)
        n_rings <= n_rings + 1;
    end
  end
endmodule : rwg_line_model

// *** testbench/tb.sv ***
// self-checking bench for the ringing waveform generator
`timescale 1ns/100ps
module tb;
  import rwg_pkg::*;
  localparam int SDIV = 16;
  logic        clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] ring_sample;
  logic [2:0]  line_state;
  logic        ring_on;
  int          n_rings;
  int          n_errors;
  int          n_compared;
  logic [31:0] r;
  logic        e;
  int          n;

  rwg_top #(.SINE_DIV_P(SDIV)) dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ring_sample(ring_sample), .line_state(line_state), .ring_on(ring_on));
  rwg_line_model line_u (.clk(clk), .resetn(resetn), .line_state(line_state), .ring_on(ring_on),
    .n_rings(n_rings));

  initial begin
    clk = 1'b0;
    forever #(CLK_NS / 2) clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd_o, output logic err);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 50) n_errors++;
    rd_o = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    apb(1'b0, {2'b00, idx, 2'b00}, 32'h0000_0000, r, e);
  endtask : rd

  // the store is reached only through the window, never directly
  task automatic ind_wr(input logic [7:0] a, input logic [15:0] d);
    wr(IDX_IND_DATA, {16'h0000, d});
    wr(IDX_IND_ADDR, {23'h000000, 1'b1, a});
  endtask : ind_wr

  task automatic ind_rd(input logic [7:0] a);
    int k;
    wr(IDX_IND_ADDR, {24'h000000, a});
    for (k = 0; k < 10; k++) begin
      rd(IDX_IND_STAT);
      if (r[0] === 1'b0) break;
    end
    rd(IDX_IND_DATA);
  endtask : ind_rd

  task automatic wait_ring(input logic v, input int lim);
    n = 0;
    while (n < lim) begin
      @(posedge clk);
      n++;
      if (ring_on === v) break;
    end
  endtask : wait_ring

  task automatic next_change(output logic [15:0] v);
    logic [15:0] prev;
    prev = ring_sample;
    n = 0;
    while (n < 5 * STEP_DIV) begin
      @(posedge clk);
      n++;
      if (ring_sample !== prev) break;
    end
    v = ring_sample;
  endtask : next_change

  function automatic logic [15:0] sine_next(input logic [15:0] c, input logic [15:0] y1,
                                            input logic [15:0] y2);
    longint p;
    p = longint'($signed(c)) * longint'($signed(y1));
    p = (p >>> 14) - longint'($signed(y2));
    return p[15:0];
  endfunction : sine_next

  task automatic t_regs();
    rd(IDX_RING_CTRL);
    chk("ctrl reset", {24'h0, CTRL_RST}, r);
    wr(IDX_ACT, 32'h0000_1234);
    rd(IDX_ACT);
    chk("active time", 32'h0000_1234, r);
    wr(IDX_BAT, 32'h0000_00ff);
    rd(IDX_BAT);
    chk("battery", 32'h0000_003f, r);
    wr(IDX_RING_CTRL, 32'h0000_001f);
    rd(IDX_RING_CTRL);
    chk("ctrl oscillator bit read-only", 32'h0000_001b, r);
    apb(1'b0, 12'h074, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    apb(1'b1, 12'h089, 32'h0000_0000, r, e);
    chk("misaligned error", 32'h1, {31'h0, e});
    rd(IDX_RING_CTRL);
    chk("misaligned write ignored", 32'h0000_001b, r);
  endtask : t_regs

  task automatic t_indirect();
    ind_wr(IND_HEAD, 16'h000a);
    ind_wr(IND_PHASE, 16'hbeef);
    ind_rd(IND_HEAD);
    chk("indirect headroom", 32'h0000_000a, r);
    ind_rd(IND_PHASE);
    chk("indirect phase", 32'h0000_beef, r);
  endtask : t_indirect

  task automatic t_sine();
    logic [15:0] y1;
    logic [15:0] y2;
    logic [15:0] v;
    // coefficient values picked within range and phase zero, as software must
    ind_wr(IND_OFS, 16'h0000);
    ind_wr(IND_FREQ, 16'h7000);
    ind_wr(IND_AMP, 16'h0400);
    ind_wr(IND_PHASE, 16'h0000);
    wr(IDX_RING_CTRL, 32'h0);
    wr(IDX_LINE, {29'h0, LINE_RING});
    chk("ring on at entry", 32'h1, {31'h0, ring_on});
    chk("line ringing", {29'h0, LINE_RING}, {29'h0, line_state});
    next_change(v);
    chk("sine seed", 32'h0000_0400, {16'h0, v});
    y1 = 16'h0400;
    y2 = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      next_change(v);
      {y1, y2} = {sine_next(16'h7000, y1, y2), y1};
      chk("sine sample", {16'h0, y1}, {16'h0, v});
      if (i > 0) chk("sine tick spacing", SDIV, n);
    end
    wr(IDX_LINE, 32'h0);
    @(posedge clk);
    chk("ring off when idle", 32'h0, {31'h0, ring_on});
    @(posedge clk);
    chk("idle sample", 32'h0, {16'h0, ring_sample});
  endtask : t_sine

  task automatic t_cadence();
    wr(IDX_ACT, 32'h1);
    wr(IDX_INACT, 32'h0);
    wr(IDX_RING_CTRL, 32'h18);
    wr(IDX_LINE, {29'h0, LINE_RING});
    wait_ring(1'b0, 4 * STEP_DIV);
    chk("first active length", 1, n >= STEP_DIV - 8 && n <= 2 * STEP_DIV + 2);
    chk("on-hook after active", {29'h0, LINE_OHT}, {29'h0, line_state});
    wait_ring(1'b1, 4 * STEP_DIV);
    chk("inactive length", 1, n >= 1 && n <= STEP_DIV + 2);
    chk("ringing again", {29'h0, LINE_RING}, {29'h0, line_state});
    wait_ring(1'b0, 4 * STEP_DIV);
    chk("second active length", 1, n >= STEP_DIV && n <= 2 * STEP_DIV + 2);
    wait_ring(1'b1, 4 * STEP_DIV);
    wr(IDX_RING_CTRL, 32'h10);
    wait_ring(1'b0, 4 * STEP_DIV);
    wait_ring(1'b1, 3 * STEP_DIV);
    chk("one-shot stays off", 32'h0, {31'h0, ring_on});
    chk("bursts seen by load", 32'h4, n_rings);
    wr(IDX_LINE, 32'h0);
  endtask : t_cadence

  task automatic t_trap();
    logic [15:0] v;
    ind_wr(IND_OFS, 16'h0100);
    ind_wr(IND_FREQ, 16'h0040);
    ind_wr(IND_AMP, 16'h0100);
    ind_wr(IND_PHASE, 16'h0010);
    wr(IDX_RING_CTRL, 32'h03);
    wr(IDX_LINE, {29'h0, LINE_RING});
    for (int i = 1; i <= 4; i++) begin
      next_change(v);
      chk("ramp sample", 32'h100 + i * 32'h40, {16'h0, v});
      if (i > 1) chk("ramp spacing", STEP_DIV, n);
    end
    wr(IDX_LINE, 32'h1);
    @(posedge clk);
    @(posedge clk);
    chk("offset only when idle", 32'h0100, {16'h0, ring_sample});
    chk("linefeed passes through", 32'h1, {29'h0, line_state});
    wr(IDX_RING_CTRL, 32'h0);
    @(posedge clk);
    chk("offset disabled", 32'h0, {16'h0, ring_sample});
  endtask : t_trap

  task automatic results();
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  initial begin
    #(80_000 * CLK_NS);
    n_errors++;
    results();
  end

  initial begin
    n_errors   = 0;
    n_compared = 0;
    resetn  = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_indirect();
    t_sine();
    t_cadence();
    t_trap();
    results();
  end
endmodule : tb
